// File: hw/pgs_pkg.sv
// Constants shared by the gain-set switching block.
// Assumes a 125 MHz clock.
package pgs_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int TIME_UNIT_NS = 100000; // 0.1 ms
    localparam int TICK_CYCLES = (TIME_UNIT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Widths
    localparam int GAIN_W = 16;
    localparam int QTY_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_GAINS = 5;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DELAY = 8'h04;
    localparam logic [7:0] OFF_LEVEL = 8'h08;
    localparam logic [7:0] OFF_HYST = 8'h0C;
    localparam logic [7:0] OFF_RAMP = 8'h10;
    localparam logic [7:0] OFF_FIRST = 8'h14;
    localparam logic [7:0] OFF_SECOND = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h3C;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 4;
    // Status register fields
    localparam int STAT_SECOND_BIT = 0;
    localparam int STAT_RAMP_BIT = 1;
    localparam int STAT_WAIT_BIT = 2;
    localparam int STAT_HYST_LSB = 16;
    // Values after reset
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [15:0] RST_PARAM = 16'h0000;
    // Trigger selector codes
    localparam logic [3:0] SEL_FIRST = 4'h0;
    localparam logic [3:0] SEL_SECOND = 4'h1;
    localparam logic [3:0] SEL_HOST = 4'h2;
    localparam logic [3:0] SEL_TORQUE = 4'h3;
    localparam logic [3:0] SEL_DISABLED = 4'h4;
    localparam logic [3:0] SEL_SPEED_CMD = 4'h5;
    localparam logic [3:0] SEL_DEVIATION = 4'h6;
    localparam logic [3:0] SEL_POS_CMD = 4'h7;
    localparam logic [3:0] SEL_NOT_DONE = 4'h8;
    localparam logic [3:0] SEL_ACT_SPEED = 4'h9;
    localparam logic [3:0] SEL_CMD_SPEED = 4'hA;
    // Control modes
    localparam logic [1:0] CM_POSITION = 2'h0;
    localparam logic [1:0] CM_FULL_CLOSED = 2'h1;
    localparam logic [1:0] CM_VELOCITY = 2'h2;
    localparam logic [1:0] CM_TORQUE = 2'h3;
    // Selection states
    typedef enum logic [1:0] {
        ST_FIRST,
        ST_SECOND,
        ST_RETURN_WAIT
    } pgs_state_e;
endpackage

// File: hw/pgs_trigger.sv
// Level comparator with hysteresis.
// Assumes an unsigned magnitude of 17 bits or more.
`timescale 1ns/1ns
`default_nettype none
module pgs_trigger #(
    parameter int QW = 32
) (
    input wire logic [QW-1:0] quantity, // Trigger magnitude
    input wire logic [15:0] level, // Switching level
    input wire logic [15:0] hyst, // Programmed hysteresis
    output logic above, // Above upper threshold
    output logic below, // Below lower threshold
    output logic [15:0] eff_hyst // Hysteresis in use
);
    logic [QW-1:0] upper;
    logic [QW-1:0] lower;

    // Clamp hysteresis to the level
    always_comb begin
        eff_hyst = (level < hyst) ? level : hyst;
    end

    // Half band each side
    always_comb begin
        upper = QW'(level) + QW'(eff_hyst[15:1]);
        lower = QW'(level) - QW'(eff_hyst[15:1]);
        above = quantity > upper;
        below = quantity < lower;
    end
endmodule
`default_nettype wire

// File: hw/pgs_ramp.sv
// Kp ramp: rises spread, falls step.
// Assumes a one-cycle tick per time unit.
`timescale 1ns/1ns
`default_nettype none
module pgs_ramp #(
    parameter int GW = 16
) (
    input wire logic ref_clk, // Servo clock
    input wire logic rst_b, // Sync reset, low
    input wire logic tick, // Time-unit strobe
    input wire logic [GW-1:0] target, // Selected gain
    input wire logic [15:0] ramp_time, // Ramp length in ticks
    output logic [GW-1:0] gain, // Gain in use
    output logic busy // Ramp in progress
);
    logic [GW-1:0] target_q;
    logic [GW-1:0] step;
    logic [15:0] left;
    logic [GW-1:0] next_gain;
    logic [GW-1:0] next_target_q;
    logic [GW-1:0] next_step;
    logic [15:0] next_left;
    logic [GW:0] sum;

    // Ramp progress
    always_comb begin
        next_gain = gain;
        next_target_q = target;
        next_step = step;
        next_left = left;
        sum = {1'b0, gain} + {1'b0, step};
        if (target != target_q) begin
            if (target > gain && ramp_time != 16'h0000) begin
                next_step = GW'((target - gain) / GW'(ramp_time));
                if (next_step == '0) begin
                    next_step = GW'(1);
                end
                next_left = ramp_time;
            end else begin
                next_gain = target;
                next_left = 16'h0000;
            end
        end else if (left != 16'h0000 && tick) begin
            next_left = left - 16'h0001;
            if (left == 16'h0001 || sum >= {1'b0, target}) begin
                next_gain = target;
                next_left = 16'h0000;
            end else begin
                next_gain = sum[GW-1:0];
            end
        end
    end

    // Ramp registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gain <= '0;
            target_q <= '0;
            step <= '0;
            left <= 16'h0000;
        end else begin
            gain <= next_gain;
            target_q <= next_target_q;
            step <= next_step;
            left <= next_left;
        end
    end

    assign busy = left != 16'h0000;
endmodule
`default_nettype wire

// File: hw/pgs_top.sv
// Gain-set switching for position and full-closed control.
// Assumes all inputs on the servo clock,
// one bus request at a time.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Enable at 0 pins the first set; at 1 switching is allowed.
// - Selector 0..10 chooses fixed set or trigger quantity.
// - Selector 2 follows the host gain-select bit of each command.
// - Selector 4 behaves as selector 0: first set kept.
// - Selector 10 triggers on position command or actual speed.
// - Modes 3 and 5..10 wait the return delay before first set.
// - Modes 3,5,6,9,10 compare their quantity against the level.
// - Those modes apply hysteresis around the level.
// - Level below hysteresis makes hysteresis equal the level.
// - Each set holds five gains switched together.
// - Switched gains depend on the active control mode.
module pgs_top
    import pgs_pkg::*;
#(
    parameter int TICK_CYCLES = pgs_pkg::TICK_CYCLES,
    parameter int QW = pgs_pkg::QTY_W
) (
    input wire logic ref_clk, // Servo clock
    input wire logic rst_b, // Sync reset, low
    input wire logic [pgs_pkg::ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic host_cmd_valid, // Command strobe
    input wire logic host_gain_select_cmd, // Host set choice
    input wire logic [1:0] control_mode, // Active control mode
    input wire logic [QW-1:0] torque_cmd_mag, // Torque command
    input wire logic [QW-1:0] speed_cmd_mag, // Speed command
    input wire logic [QW-1:0] position_deviation_mag, // Deviation
    input wire logic [QW-1:0] actual_speed_mag, // Actual speed
    input wire logic position_cmd_present, // Command pulses now
    input wire logic positioning_complete, // In position
    output logic [pgs_pkg::GAIN_W-1:0] position_loop_gain, // Kp
    output logic [pgs_pkg::GAIN_W-1:0] velocity_loop_gain, // Kv
    output logic [pgs_pkg::GAIN_W-1:0] velocity_integration_tc, // Ti
    output logic [pgs_pkg::GAIN_W-1:0] velocity_detect_filter, // Filt
    output logic [pgs_pkg::GAIN_W-1:0] torque_filter_tc, // Tf
    output logic second_set_active // Second set in use
);
    import pgs_pkg::*;

    // Merge low byte lanes into a 16-bit field
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Gain word index in a set, else 7
    function automatic logic [2:0] gain_index(
        input logic [7:0] addr,
        input logic [7:0] base
    );
        logic [7:0] d;
        d = addr - base;
        if (addr >= base && d[1:0] == 2'b00
                && d[7:2] < 6'(NUM_GAINS)) begin
            return d[4:2];
        end
        return 3'h7;
    endfunction

    // Software-written configuration
    logic enable;
    logic [3:0] sel;
    logic [15:0] ret_delay;
    logic [15:0] level;
    logic [15:0] hyst;
    logic [15:0] ramp_time;
    logic [GAIN_W-1:0] first_set [NUM_GAINS];
    logic [GAIN_W-1:0] second_set [NUM_GAINS];
    logic next_enable;
    logic [3:0] next_sel;
    logic [15:0] next_ret_delay;
    logic [15:0] next_level;
    logic [15:0] next_hyst;
    logic [15:0] next_ramp_time;
    logic [GAIN_W-1:0] next_first_set [NUM_GAINS];
    logic [GAIN_W-1:0] next_second_set [NUM_GAINS];

    // Bus handshake
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [31:0] rd_mux;
    logic wr_take;
    logic [2:0] fidx;
    logic [2:0] sidx;

    // Switching state
    pgs_state_e state;
    pgs_state_e next_state;
    logic [31:0] dly_cnt;
    logic [31:0] next_dly_cnt;
    logic host_sel;
    logic next_host_sel;
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    logic tick;

    // Trigger and output signals
    logic [QW-1:0] quantity;
    logic above;
    logic below;
    logic [15:0] eff_hyst;
    logic go_second;
    logic go_first;
    logic use_second;
    logic pos_mode;
    logic ramp_busy;
    logic [GAIN_W-1:0] kp_target;
    logic [GAIN_W-1:0] next_vel_gain;
    logic [GAIN_W-1:0] next_vel_int;
    logic [GAIN_W-1:0] next_vel_filt;
    logic [GAIN_W-1:0] next_trq_filt;

    // One wait state; write lands with waitrequest low
    always_comb begin
        avs_waitrequest = (avs_read | avs_write) & ~ack;
        next_ack = (avs_read | avs_write) & ~ack;
        wr_take = avs_write & ack;
        fidx = gain_index(avs_address, OFF_FIRST);
        sidx = gain_index(avs_address, OFF_SECOND);
    end

    // Read mux; unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address == OFF_CTRL) begin
            rd_mux[CTRL_EN_BIT] = enable;
            rd_mux[CTRL_SEL_LSB +: 4] = sel;
        end else if (avs_address == OFF_DELAY) begin
            rd_mux[15:0] = ret_delay;
        end else if (avs_address == OFF_LEVEL) begin
            rd_mux[15:0] = level;
        end else if (avs_address == OFF_HYST) begin
            rd_mux[15:0] = hyst;
        end else if (avs_address == OFF_RAMP) begin
            rd_mux[15:0] = ramp_time;
        end else if (fidx != 3'h7) begin
            rd_mux[GAIN_W-1:0] = first_set[fidx];
        end else if (sidx != 3'h7) begin
            rd_mux[GAIN_W-1:0] = second_set[sidx];
        end else if (avs_address == OFF_STATUS) begin
            rd_mux[STAT_SECOND_BIT] = use_second;
            rd_mux[STAT_RAMP_BIT] = ramp_busy;
            rd_mux[STAT_WAIT_BIT] = state == ST_RETURN_WAIT;
            rd_mux[STAT_HYST_LSB +: 16] = eff_hyst;
        end
        next_readdata = (avs_read & ~ack) ? rd_mux : avs_readdata;
    end

    // Register writes
    always_comb begin
        next_enable = enable;
        next_sel = sel;
        next_ret_delay = ret_delay;
        next_level = level;
        next_hyst = hyst;
        next_ramp_time = ramp_time;
        next_first_set = first_set;
        next_second_set = second_set;
        if (wr_take) begin
            if (avs_address == OFF_CTRL && avs_byteenable[0]) begin
                next_enable = avs_writedata[CTRL_EN_BIT];
                next_sel = avs_writedata[CTRL_SEL_LSB +: 4];
            end
            if (avs_address == OFF_DELAY) begin
                next_ret_delay = merge16(ret_delay, avs_writedata,
                    avs_byteenable);
            end
            if (avs_address == OFF_LEVEL) begin
                next_level = merge16(level, avs_writedata,
                    avs_byteenable);
            end
            if (avs_address == OFF_HYST) begin
                next_hyst = merge16(hyst, avs_writedata,
                    avs_byteenable);
            end
            if (avs_address == OFF_RAMP) begin
                next_ramp_time = merge16(ramp_time, avs_writedata,
                    avs_byteenable);
            end
            if (fidx != 3'h7) begin
                next_first_set[fidx] = merge16(first_set[fidx],
                    avs_writedata, avs_byteenable);
            end
            if (sidx != 3'h7) begin
                next_second_set[sidx] = merge16(second_set[sidx],
                    avs_writedata, avs_byteenable);
            end
        end
    end

    // Tick and host latch
    always_comb begin
        tick = tick_cnt == 16'(TICK_CYCLES - 1);
        next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
        next_host_sel = host_cmd_valid ? host_gain_select_cmd
            : host_sel;
    end

    // Quantity chosen by the selector
    always_comb begin
        case (sel)
            SEL_TORQUE: quantity = torque_cmd_mag;
            SEL_SPEED_CMD: quantity = speed_cmd_mag;
            SEL_DEVIATION: quantity = position_deviation_mag;
            default: quantity = actual_speed_mag;
        endcase
    end

    pgs_trigger #(
        .QW(QW)
    ) u_trigger (
        .quantity(quantity),
        .level(level),
        .hyst(hyst),
        .above(above),
        .below(below),
        .eff_hyst(eff_hyst)
    );

    // Second-set entry and exit
    always_comb begin
        case (sel)
            SEL_TORQUE, SEL_SPEED_CMD, SEL_DEVIATION,
            SEL_ACT_SPEED: begin
                go_second = above;
                go_first = below;
            end
            SEL_POS_CMD: begin
                go_second = position_cmd_present;
                go_first = ~position_cmd_present;
            end
            SEL_NOT_DONE: begin
                go_second = ~positioning_complete;
                go_first = positioning_complete;
            end
            SEL_CMD_SPEED: begin
                go_second = position_cmd_present | above;
                go_first = ~position_cmd_present & below;
            end
            default: begin
                go_second = 1'b0;
                go_first = 1'b0;
            end
        endcase
    end

    // Set selection with return delay
    always_comb begin
        next_state = state;
        next_dly_cnt = dly_cnt;
        if (!enable || sel == SEL_FIRST || sel == SEL_DISABLED
                || sel > SEL_CMD_SPEED) begin
            next_state = ST_FIRST;
        end else if (sel == SEL_SECOND) begin
            next_state = ST_SECOND;
        end else if (sel == SEL_HOST) begin
            next_state = host_sel ? ST_SECOND : ST_FIRST;
        end else begin
            case (state)
                ST_FIRST: begin
                    if (go_second) begin
                        next_state = ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    if (go_first) begin
                        next_dly_cnt = 32'(ret_delay)
                            * 32'(TICK_CYCLES);
                        next_state = (ret_delay == 16'h0000)
                            ? ST_FIRST : ST_RETURN_WAIT;
                    end
                end
                ST_RETURN_WAIT: begin
                    if (go_second) begin
                        next_state = ST_SECOND;
                    end else if (dly_cnt <= 32'h0000_0001) begin
                        next_state = ST_FIRST;
                    end else begin
                        next_dly_cnt = dly_cnt - 32'h0000_0001;
                    end
                end
                default: next_state = ST_FIRST;
            endcase
        end
    end

    // Gains handed to the loops
    always_comb begin
        use_second = state != ST_FIRST;
        pos_mode = control_mode == CM_POSITION
            || control_mode == CM_FULL_CLOSED;
        // Kp follows the set in position modes only
        kp_target = (pos_mode && use_second) ? second_set[0]
            : first_set[0];
        next_vel_gain = use_second ? second_set[1] : first_set[1];
        next_vel_int = use_second ? second_set[2] : first_set[2];
        next_vel_filt = use_second ? second_set[3] : first_set[3];
        next_trq_filt = use_second ? second_set[4]
            : first_set[4];
    end

    pgs_ramp #(
        .GW(GAIN_W)
    ) u_ramp (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(tick),
        .target(kp_target),
        .ramp_time(ramp_time),
        .gain(position_loop_gain),
        .busy(ramp_busy)
    );

    // State and register updates
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            enable <= RST_ENABLE;
            sel <= RST_SEL;
            ret_delay <= RST_PARAM;
            level <= RST_PARAM;
            hyst <= RST_PARAM;
            ramp_time <= RST_PARAM;
            for (int i = 0; i < NUM_GAINS; i++) begin
                first_set[i] <= RST_PARAM;
                second_set[i] <= RST_PARAM;
            end
            state <= ST_FIRST;
            dly_cnt <= 32'h0000_0000;
            host_sel <= 1'b0;
            tick_cnt <= 16'h0000;
            velocity_loop_gain <= RST_PARAM;
            velocity_integration_tc <= RST_PARAM;
            velocity_detect_filter <= RST_PARAM;
            torque_filter_tc <= RST_PARAM;
            second_set_active <= 1'b0;
        end else begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
            enable <= next_enable;
            sel <= next_sel;
            ret_delay <= next_ret_delay;
            level <= next_level;
            hyst <= next_hyst;
            ramp_time <= next_ramp_time;
            first_set <= next_first_set;
            second_set <= next_second_set;
            state <= next_state;
            dly_cnt <= next_dly_cnt;
            host_sel <= next_host_sel;
            tick_cnt <= next_tick_cnt;
            velocity_loop_gain <= next_vel_gain;
            velocity_integration_tc <= next_vel_int;
            velocity_detect_filter <= next_vel_filt;
            torque_filter_tc <= next_trq_filt;
            second_set_active <= use_second;
        end
    end
endmodule
`default_nettype wire

// File: tb/pgs_checker.sv
// Bound assertions on the switching top.
// Assumes full-lane register writes.
`timescale 1ns/1ns
`default_nettype none
module pgs_checker
    import pgs_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, low
    input wire logic [pgs_pkg::ADDR_W-1:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Data
    input wire logic avs_waitrequest, // Stall
    input wire logic host_cmd_valid, // Command strobe
    input wire logic host_gain_select_cmd, // Host bit
    input wire logic [31:0] actual_speed_mag, // Speed
    input wire logic second_set_active // Set in use
);
    logic [7:0] ctl;
    logic [3:0] sel;
    logic [15:0] dly, lvl, hy, eh;
    logic [16:0] hi;
    logic fix1, fix2, hostm, lvm;
    // Shadow config registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctl <= '0;
            dly <= '0;
            lvl <= '0;
            hy <= '0;
        end else if (avs_write && !avs_waitrequest) begin
            case (avs_address)
                OFF_CTRL: ctl <= avs_writedata[7:0];
                OFF_DELAY: dly <= avs_writedata[15:0];
                OFF_LEVEL: lvl <= avs_writedata[15:0];
                OFF_HYST: hy <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end
    // Mode decode
    assign sel = ctl[7:4];
    assign eh = lvl < hy ? lvl : hy;
    assign hi = lvl + eh[15:1];
    assign fix1 = !ctl[0] || sel == SEL_FIRST || sel == SEL_DISABLED
        || sel > SEL_CMD_SPEED;
    assign fix2 = ctl[0] && sel == SEL_SECOND;
    assign hostm = ctl[0] && sel == SEL_HOST;
    assign lvm = ctl[0] && sel == SEL_ACT_SPEED;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    chk_bus_idle: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("stall without request");
    chk_bus_stall: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state");
    chk_bus_once: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    chk_fixed_first: assert property (
        fix1[*3] |-> !second_set_active)
        else $error("second set when fixed first");
    chk_fixed_second: assert property (
        fix2[*3] |-> second_set_active)
        else $error("first set in fixed-second mode");
    chk_host_bit: assert property (
        hostm && host_cmd_valid ##1 hostm
        |-> ##2 second_set_active == $past(host_gain_select_cmd, 3))
        else $error("host select not followed");
    chk_level_rise: assert property (
        lvm && actual_speed_mag > hi |-> ##2 second_set_active)
        else $error("no switch above level");
    chk_return_wait: assert property (
        $fell(second_set_active) && lvm && dly != 0
        |-> $past(second_set_active, 4))
        else $error("return without delay");
    cover property (fix2 ##2 second_set_active);
    cover property (hostm && host_cmd_valid);
    cover property ($fell(second_set_active) && lvm && dly != 0);
endmodule
bind pgs_top pgs_checker u_chk (.*);
`default_nettype wire

// File: tb/pgs_host_ctl.sv
// Motion controller model sending set choices.
// Assumes one-cycle send pulses.
`timescale 1ns/1ns
`default_nettype none
module pgs_host_ctl (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, low
    input wire logic send, // Issue a command
    input wire logic choice, // Set wanted
    output logic host_cmd_valid, // Command strobe
    output logic host_gain_select_cmd // Set choice bit
);
    // Bit toggles when idle, so stale bits show
    always_ff @(posedge ref_clk) begin
        host_cmd_valid <= rst_b && send;
        host_gain_select_cmd <= rst_b && (send ? choice
            : !host_gain_select_cmd);
    end
endmodule
`default_nettype wire

// File: tb/position_gain_set_switching_tb_top.sv
// Bench with a cycle model of the selection.
// Assumes a time unit of TK clocks.
`timescale 1ns/1ns
`default_nettype none
module position_gain_set_switching_tb_top;
    import pgs_pkg::*;
    localparam int TK = 4;
    logic ref_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, host_cmd_valid, host_gain_select_cmd;
    logic second_set_active, send = 0, choice = 0;
    logic [1:0] control_mode = 0;
    logic [31:0] torque_cmd_mag = 0, speed_cmd_mag = 0;
    logic [31:0] position_deviation_mag = 0, actual_speed_mag = 0;
    logic position_cmd_present = 0, positioning_complete = 0;
    logic [15:0] position_loop_gain, velocity_loop_gain;
    logic [15:0] velocity_integration_tc, velocity_detect_filter;
    logic [15:0] torque_filter_tc;
    int errors = 0, num_checks = 0;
    int sel, eh, q, tr, rt, lv, hv, hl = 0, st = 0, cnt = 0, om = 0;
    int rg[15] = '{default: 0}, pg[15] = '{default: 0};
    pgs_top #(.TICK_CYCLES(TK)) dut (.*);
    pgs_host_ctl host (.*);
    initial forever #4 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) errors++;
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Reference model, one step per edge
    always @(posedge ref_clk) begin
        if (rst_b) begin
            check(second_set_active, om);
            check(velocity_loop_gain, pg[6 + 5 * om]);
            check(velocity_integration_tc, pg[7 + 5 * om]);
            check(velocity_detect_filter, pg[8 + 5 * om]);
            check(torque_filter_tc, pg[9 + 5 * om]);
            om = st != 0;
            pg = rg;
            sel = rg[0][7:4];
            eh = rg[2] < rg[3] ? rg[2] : rg[3];
            case (sel)
                3: q = torque_cmd_mag;
                5: q = speed_cmd_mag;
                6: q = position_deviation_mag;
                default: q = actual_speed_mag;
            endcase
            tr = q > rg[2] + eh / 2;
            rt = q < rg[2] - eh / 2;
            if (sel == 7 || sel == 10) begin
                tr = position_cmd_present || (sel == 10 && tr);
                rt = !position_cmd_present && (sel == 10 ? rt : 1);
            end
            if (sel == 8) begin
                tr = !positioning_complete;
                rt = positioning_complete;
            end
            if (!rg[0][0] || sel == 0 || sel == 4 || sel > 10) st = 0;
            else if (sel < 3) st = sel == 1 ? 1 : hl;
            else if (tr) st = 1;
            else if (st == 1 && rt) begin
                cnt = rg[1] * TK;
                st = cnt ? 2 : 0;
            end else if (st == 2 && --cnt == 0) st = 0;
            if (host_cmd_valid) hl = host_gain_select_cmd;
            if (avs_write && !avs_waitrequest && avs_address < 8'h3C)
                rg[avs_address >> 2] = avs_writedata[15:0];
        end
    end
    initial begin
        #400000;
        errors++;
        summarize();
    end
    initial begin
        void'($urandom(79641));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 5; i < 15; i++) bus(1'b1, 8'(i * 4), $urandom, rd);
        bus(1'b0, 8'h40, 0, rd);
        check(rd, 0);
        bus(1'b0, OFF_LEVEL, 0, rd);
        check(rd, rg[2]);
        // All selectors, off and on, random inputs
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 16; s++) begin
                lv = $urandom % 2000;
                hv = $urandom % 3000; // at times above level
                bus(1'b1, OFF_DELAY, $urandom % 3, rd);
                bus(1'b1, OFF_LEVEL, lv, rd);
                bus(1'b1, OFF_HYST, hv, rd);
                bus(1'b1, OFF_CTRL, s * 16 + e, rd);
                bus(1'b0, OFF_STATUS, 0, rd);
                check(rd[31:16], lv < hv ? lv : hv);
                repeat (20) begin
                    torque_cmd_mag <= $urandom % 4000;
                    speed_cmd_mag <= $urandom % 4000;
                    position_deviation_mag <= $urandom % 4000;
                    actual_speed_mag <= $urandom % 4000;
                    {position_cmd_present, positioning_complete} <= $urandom;
                    {send, choice} <= $urandom;
                    control_mode <= $urandom;
                    @(posedge ref_clk);
                    send <= 1'b0;
                    repeat (3) @(posedge ref_clk);
                end
            end
        end
        // Kp ramps up, steps down, held outside position
        control_mode <= CM_POSITION;
        bus(1'b1, OFF_RAMP, 2, rd);
        bus(1'b1, OFF_FIRST, 100, rd);
        bus(1'b1, OFF_SECOND, 300, rd);
        bus(1'b1, OFF_CTRL, 8'h11, rd);
        repeat (3) @(posedge ref_clk);
        check(position_loop_gain < 300, 1);
        repeat (3 * TK + 4) @(posedge ref_clk);
        check(position_loop_gain, 300);
        bus(1'b1, OFF_CTRL, 1, rd);
        repeat (3) @(posedge ref_clk);
        check(position_loop_gain, 100);
        control_mode <= CM_VELOCITY;
        bus(1'b1, OFF_CTRL, 8'h11, rd);
        repeat (4 * TK) @(posedge ref_clk);
        check(position_loop_gain, 100);
        summarize();
    end
endmodule
`default_nettype wire
